// ===== sensor_result_regs.sv
// Result register slice: result bytes, sample queue read port and keyed reset.
//
// Operation
// - Z result maps only its low byte, which carries six low bits in [7:2].
// - Temperature reads as 14-bit value split high eight, low six bits.
// - Auxiliary converter result reads as 14-bit value split high and low.
// - Bits one and zero of every low result byte read zero.
// - Reading the queue port directly removes one sample word.
// - Continued reading of the queue port keeps removing successive words.
// - A burst started at the queue port keeps the address pointer fixed.
// - Auto-increment onto the queue port skips it without removing a word.
// - Writing the key to the reset byte resets results and enters standby.
// - After keyed reset the interrupt pins float, held by keepers.
// - The reset byte is write-only and always reads zero.
`timescale 1ns/1ps
module sensor_result_regs
  import result_regs_pkg::*;
#(
  parameter int unsigned RESET_LATENCY_CYCLES = SOFT_RESET_LATENCY_CYCLES
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          txn_start_i,
  input  wire logic [7:0]    txn_addr_i,
  input  wire logic          byte_rd_i,
  input  wire logic          byte_wr_i,
  input  wire logic [7:0]    byte_wdata_i,
  output logic [7:0]         rdata_o,
  output logic               rdata_valid_o,
  input  wire logic          result_load_i,
  input  wire logic [13:0]   z_accel_value_i,
  input  wire logic [13:0]   temp_value_i,
  input  wire logic [13:0]   aux_converter_value_i,
  input  wire logic          measure_start_i,
  input  wire logic          int_drive_en_i,
  input  wire logic          sample_valid_i,
  input  wire logic [15:0]   sample_data_i,
  output logic               sample_ready_o,
  output logic               soft_reset_o,
  output logic               standby_o,
  output logic               int_hiz_o,
  output logic               reset_busy_o
);

  // The latency counter must hold the requested count.
  if (RESET_LATENCY_CYCLES < 1 || RESET_LATENCY_CYCLES >= (1 << LATENCY_W)) begin : g_check
    $error("RESET_LATENCY_CYCLES does not fit the latency counter.");
  end

  typedef struct packed {
    logic [7:0]           ptr;
    logic                 fixed;
    logic                 half;
    logic [7:0]           low_hold;
    logic [13:0]          z_val;
    logic [13:0]          t_val;
    logic [13:0]          a_val;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 soft_rst;
    logic                 standby;
    logic                 int_hiz;
    logic                 busy;
    logic [LATENCY_W-1:0] busy_cnt;
  } state_t;

  localparam state_t STATE_RESET = '{
    ptr:      8'h00,
    fixed:    1'b0,
    half:     1'b0,
    low_hold: 8'h00,
    z_val:    RESULT_RESET,
    t_val:    RESULT_RESET,
    a_val:    RESULT_RESET,
    rdata:    READ_ZERO,
    rvalid:   1'b0,
    soft_rst: 1'b0,
    standby:  STANDBY_RESET,
    int_hiz:  INT_HIZ_RESET,
    busy:     1'b0,
    busy_cnt: '0
  };

  state_t             s_q;
  state_t             s_d;
  logic               q_valid;
  logic [15:0]        q_data;
  logic               q_pop;
  logic               key_hit;

  // Pointer after one byte: held in a burst at the port, and the port is
  // stepped over so that sweeping the map never drains the queue.
  function automatic logic [7:0] next_ptr(input logic [7:0] ptr, input logic fixed);
    logic [7:0] p;
    p = ptr + 8'h01;
    if (fixed) begin
      p = ptr;
    end else if (p == ADDR_SAMPLE_PORT) begin
      p = ptr + 8'h02;
    end
    return p;
  endfunction : next_ptr

  // Low result byte: six low bits left aligned over a zero pad.
  function automatic logic [7:0] low_byte(input logic [13:0] v);
    return {v[HIGH_LSB-1:0], LOW_PAD};
  endfunction : low_byte

  // Byte view of the plain result registers; unknown addresses read zero.
  function automatic logic [7:0] result_byte(input logic [7:0]  addr,
                                             input logic [13:0] z,
                                             input logic [13:0] t,
                                             input logic [13:0] a);
    logic [7:0] b;
    b = READ_ZERO;
    case (addr)
      ADDR_Z_ACCEL_LOW:   b = low_byte(z);
      ADDR_TEMP_HIGH:     b = t[RESULT_W-1:HIGH_LSB];
      ADDR_TEMP_LOW:      b = low_byte(t);
      ADDR_AUX_CONV_HIGH: b = a[RESULT_W-1:HIGH_LSB];
      ADDR_AUX_CONV_LOW:  b = low_byte(a);
      ADDR_RESET_COMMAND: b = READ_ZERO;
      default:            b = READ_ZERO;
    endcase
    return b;
  endfunction : result_byte

  // Sample words wait here, so a host that pauses between reads loses none.
  sample_skid_buffer #(
    .WIDTH (SAMPLE_W),
    .DEPTH (SAMPLE_DEPTH)
  ) u_sample_buf (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (s_q.soft_rst),
    .in_valid_i  (sample_valid_i),
    .in_data_i   (sample_data_i),
    .in_ready_o  (sample_ready_o),
    .out_valid_o (q_valid),
    .out_data_o  (q_data),
    .out_ready_i (q_pop)
  );

  // A read in the same cycle takes the bus, so the key only acts on a lone write.
  assign key_hit = byte_wr_i && !byte_rd_i && !txn_start_i
                   && (s_q.ptr == ADDR_RESET_COMMAND) && (byte_wdata_i == RESET_KEY);

  // Next state: bus access, result capture, keyed reset and latency timer.
  always_comb begin
    s_d          = s_q;
    q_pop        = 1'b0;
    s_d.rvalid   = 1'b0;
    s_d.soft_rst = 1'b0;

    // Results follow the measurement path only while measuring.
    if (result_load_i && !s_q.standby) begin
      s_d.z_val = z_accel_value_i;
      s_d.t_val = temp_value_i;
      s_d.a_val = aux_converter_value_i;
    end

    if (measure_start_i) begin
      s_d.standby = 1'b0;
    end
    if (int_drive_en_i) begin
      s_d.int_hiz = 1'b0;
    end

    // Latency timer; the host owns the wait, this only shows it.
    if (s_q.busy) begin
      if (s_q.busy_cnt == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.busy_cnt = s_q.busy_cnt - LATENCY_W'(1);
      end
    end

    if (txn_start_i) begin
      // A new transaction loads the pointer and notes a direct port access.
      s_d.ptr   = txn_addr_i;
      s_d.fixed = (txn_addr_i == ADDR_SAMPLE_PORT);
      s_d.half  = 1'b0;
    end else if (byte_rd_i) begin
      s_d.rvalid = 1'b1;
      if (s_q.ptr == ADDR_SAMPLE_PORT && s_q.fixed) begin
        if (!s_q.half) begin
          // First byte of a word removes it from the queue; empty reads zero.
          q_pop        = q_valid;
          s_d.rdata    = q_valid ? q_data[15:8] : READ_ZERO;
          s_d.low_hold = q_valid ? q_data[7:0] : READ_ZERO;
          s_d.half     = 1'b1;
        end else begin
          s_d.rdata = s_q.low_hold;
          s_d.half  = 1'b0;
        end
      end else begin
        s_d.rdata = result_byte(s_q.ptr, s_q.z_val, s_q.t_val, s_q.a_val);
      end
      s_d.ptr = next_ptr(s_q.ptr, s_q.fixed);
    end else if (byte_wr_i) begin
      // Every byte here is read-only except the reset byte; only the key acts.
      s_d.ptr = next_ptr(s_q.ptr, s_q.fixed);
    end

    // Keyed reset wins over every other update in the same cycle.
    if (key_hit) begin
      s_d          = STATE_RESET;
      s_d.soft_rst = 1'b1;
      s_d.standby  = 1'b1;
      s_d.int_hiz  = 1'b1;
      s_d.busy     = 1'b1;
      s_d.busy_cnt = LATENCY_W'(RESET_LATENCY_CYCLES - 1);
    end
  end

  // State register; keyed reset reuses the power-on image.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_o       = s_q.rdata;
  assign rdata_valid_o = s_q.rvalid;
  assign soft_reset_o  = s_q.soft_rst;
  assign standby_o     = s_q.standby;
  assign int_hiz_o     = s_q.int_hiz;
  assign reset_busy_o  = s_q.busy;

  // Checks on the read path, the queue port, keyed reset, standby and the latency timer.
  logic rd_plain;
  assign rd_plain = byte_rd_i && !txn_start_i && !key_hit;

  AST_Z_LOW_LAYOUT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_Z_ACCEL_LOW
    |=> rdata_valid_o && rdata_o == {$past(s_q.z_val[5:0]), 2'h0})
    else $error("Z low byte does not show the six low result bits.");

  AST_TEMP_HIGH_LAYOUT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_TEMP_HIGH
    |=> rdata_o == $past(s_q.t_val[13:6]))
    else $error("Temperature high byte does not show the upper eight bits.");

  AST_AUX_SPLIT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_AUX_CONV_HIGH ##1 rd_plain && s_q.ptr == ADDR_AUX_CONV_LOW
    && $stable(s_q.a_val)
    |=> {$past(rdata_o), rdata_o[7:2]} == $past(s_q.a_val))
    else $error("Auxiliary high and low bytes do not rebuild the result.");

  AST_LOW_PAD_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && (s_q.ptr == ADDR_Z_ACCEL_LOW || s_q.ptr == ADDR_TEMP_LOW
                 || s_q.ptr == ADDR_AUX_CONV_LOW)
    |=> rdata_o[1:0] == 2'h0)
    else $error("Reserved low bits of a result byte are not zero.");

  AST_PORT_POPS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_SAMPLE_PORT && s_q.fixed && !s_q.half && q_valid
    |-> q_pop ##1 (rdata_o == $past(q_data[15:8]) && s_q.half))
    else $error("Direct port read did not remove a sample word.");

  AST_SECOND_BYTE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.fixed && s_q.half
    |-> !q_pop ##1 (rdata_o == $past(s_q.low_hold) && !s_q.half))
    else $error("Second byte of a word is not the held low byte.");

  AST_PTR_FIXED: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_plain || (byte_wr_i && !txn_start_i && !key_hit)) && s_q.fixed
    |=> $stable(s_q.ptr) && s_q.ptr == ADDR_SAMPLE_PORT)
    else $error("Pointer moved during a burst at the queue port.");

  AST_PORT_SKIPPED: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_AUX_CONV_LOW && !s_q.fixed
    |-> !q_pop ##1 s_q.ptr == 8'h19)
    else $error("Auto-increment did not step over the queue port.");

  AST_KEY_RESETS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    key_hit |=> soft_reset_o && standby_o && int_hiz_o && reset_busy_o
    && s_q.z_val == RESULT_RESET ##1 !soft_reset_o)
    else $error("Key write did not reset the slice into standby.");

  AST_RESET_READS_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_RESET_COMMAND |=> rdata_o == 8'h00)
    else $error("Reset byte did not read zero.");

  AST_WRONG_KEY_IGNORED: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    byte_wr_i && !txn_start_i && s_q.ptr == ADDR_RESET_COMMAND && byte_wdata_i != 8'h52
    && !measure_start_i && !int_drive_en_i && !result_load_i
    |=> !soft_reset_o && $stable(standby_o) && $stable(s_q.z_val))
    else $error("A non-key write to the reset byte changed state.");

  AST_PORT_EMPTY_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain && s_q.ptr == ADDR_SAMPLE_PORT && s_q.fixed && !s_q.half && !q_valid
    |-> !q_pop ##1 (rdata_o == READ_ZERO && s_q.half))
    else $error("Empty port read did not return zero.");

  AST_READ_ANSWERED: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_plain |=> rdata_valid_o)
    else $error("A byte read got no answer strobe.");

  AST_NO_SPARE_ANSWER: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !rd_plain |=> !rdata_valid_o)
    else $error("Answer strobe rose without a byte read.");

  AST_HIZ_HELD: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !int_drive_en_i && !key_hit |=> $stable(int_hiz_o))
    else $error("Interrupt float state changed without a cause.");

  AST_STANDBY_FROZEN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    standby_o && !key_hit
    |=> $stable(s_q.z_val) && $stable(s_q.t_val) && $stable(s_q.a_val))
    else $error("Results moved while in standby.");

  AST_QUEUE_FLUSHED: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    soft_reset_o |=> !q_valid)
    else $error("Sample buffer kept words across a keyed reset.");

  AST_BUSY_COUNTS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reset_busy_o && s_q.busy_cnt != '0 && !key_hit
    |=> reset_busy_o && s_q.busy_cnt == $past(s_q.busy_cnt) - LATENCY_W'(1))
    else $error("Reset latency counter did not step down.");

  AST_BUSY_ENDS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reset_busy_o && s_q.busy_cnt == '0 && !key_hit |=> !reset_busy_o)
    else $error("Busy flag outlived the reset latency.");

endmodule : sensor_result_regs

// ===== result_regs_pkg.sv
// Package with the register map, reset values and timing of the result register slice.
package result_regs_pkg;

  // Register addresses on the serial register bus.
  localparam logic [7:0] ADDR_Z_ACCEL_LOW     = 8'h13;
  localparam logic [7:0] ADDR_TEMP_HIGH       = 8'h14;
  localparam logic [7:0] ADDR_TEMP_LOW        = 8'h15;
  localparam logic [7:0] ADDR_AUX_CONV_HIGH   = 8'h16;
  localparam logic [7:0] ADDR_AUX_CONV_LOW    = 8'h17;
  localparam logic [7:0] ADDR_SAMPLE_PORT     = 8'h18;
  localparam logic [7:0] ADDR_RESET_COMMAND   = 8'h1f;

  // Result layout: 14-bit values, upper part in the high byte, lower part left aligned.
  localparam int         RESULT_W             = 14;
  localparam int         HIGH_LSB             = 6;
  localparam logic [1:0] LOW_PAD              = 2'h0;

  // Reset values and the reset key.
  localparam logic [7:0]  READ_ZERO           = 8'h00;
  localparam logic [13:0] RESULT_RESET        = 14'h0000;
  localparam logic [7:0]  RESET_KEY           = 8'h52;
  localparam logic        STANDBY_RESET       = 1'b1;
  localparam logic        INT_HIZ_RESET       = 1'b1;

  // Sample word from the queue and its buffering.
  localparam int          SAMPLE_W            = 16;
  localparam int          SAMPLE_DEPTH        = 2;

  // Quiet time after a key write, in milliseconds, and its count of core cycles.
  localparam real         SOFT_RESET_LATENCY_MS = 7.5;
  localparam real         CORE_CLK_MHZ          = 25.0;
  localparam int unsigned SOFT_RESET_LATENCY_CYCLES =
    int'(SOFT_RESET_LATENCY_MS * 1000.0 * CORE_CLK_MHZ);
  localparam int          LATENCY_W           = 18;

endpackage : result_regs_pkg

// ===== sample_skid_buffer.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sample_skid_buffer
  import result_regs_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = SAMPLE_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int CW = $clog2(DEPTH + 1);

  // Depth below two cannot absorb a stall without a dead cycle.
  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("sample_skid_buffer needs DEPTH of at least 2 and WIDTH of at least 1.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
    logic                        in_ready;
  } buf_state_t;

  localparam buf_state_t BUF_RESET = '{mem: '0, count: '0, in_ready: 1'b1};

  buf_state_t s_q;
  buf_state_t s_d;
  logic       push;
  logic       pop;

  // Head sits in slot zero; a pop shifts, a push writes behind the last word.
  always_comb begin
    s_d  = s_q;
    pop  = out_ready_i && (s_q.count != '0);
    push = in_valid_i && s_q.in_ready;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_d.mem[i] = s_q.mem[i + 1];
      end
      s_d.count = s_q.count - CW'(1);
    end
    if (push) begin
      s_d.mem[s_d.count] = in_data_i;
      s_d.count          = s_d.count + CW'(1);
    end
    if (flush_i) begin
      s_d.count = '0;
    end
    // Ready is registered so the source sees a clean flop, at the cost of no
    // same-cycle refill when full.
    s_d.in_ready = (s_d.count != CW'(DEPTH));
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= BUF_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready_o  = s_q.in_ready;
  assign out_valid_o = (s_q.count != '0);
  assign out_data_o  = s_q.mem[0];

endmodule : sample_skid_buffer

// ===== sample_source.sv
// Behavioural model of the sample queue that feeds words to the result register slice.
`timescale 1ns/1ps
module sample_source
  import result_regs_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                hold_i,
  input  wire logic                sample_ready_i,
  output logic                     sample_valid_o,
  output logic [SAMPLE_W-1:0]      sample_data_o
);
  logic [SAMPLE_W-1:0] words_q [$];
  logic [SAMPLE_W-1:0] last_q;
  logic                offer_q;

  // Queue a word to be offered; the bench calls this between clock edges.
  task automatic push(input logic [SAMPLE_W-1:0] w);
    words_q.push_back(w);
  endtask : push

  initial begin
    sample_valid_o = 1'b0;
    sample_data_o  = 16'h0000;
    last_q         = 16'h0000;
  end

  // Handshake and the next offer are decided on the edge, so bench changes made
  // 1 ns after an edge never race the model; the offer lands 1 ns later.
  // Idle data is the inverse of the last word, so a stale bus never looks valid.
  always @(posedge core_clk_i) begin
    if (rst_n_i && sample_valid_o && sample_ready_i) begin
      last_q = words_q.pop_front();
    end
    offer_q = (words_q.size() > 0) && !hold_i;
    #1;
    if (offer_q) begin
      sample_valid_o = 1'b1;
      sample_data_o  = words_q[0];
    end else begin
      sample_valid_o = 1'b0;
      sample_data_o  = ~last_q;
    end
  end
endmodule : sample_source

// ===== tb_top.sv
// Self-checking testbench for the result register slice.
`timescale 1ns/1ps
module tb_top
  import result_regs_pkg::*;
;
  localparam int LAT = 8;
  logic        core_clk_i, rst_n_i, txn_start, byte_rd, byte_wr, rvalid, load, meas;
  logic        int_en, s_valid, s_ready, soft_rst, standby, hiz, busy, hold;
  logic [7:0]  txn_addr, wdata, rdata;
  logic [13:0] z, t, a;
  logic [15:0] s_data;
  int          n_fail, n_checks;

  sensor_result_regs #(.RESET_LATENCY_CYCLES(LAT)) sensor_result_regs_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .txn_start_i(txn_start),
    .txn_addr_i(txn_addr), .byte_rd_i(byte_rd), .byte_wr_i(byte_wr),
    .byte_wdata_i(wdata), .rdata_o(rdata), .rdata_valid_o(rvalid),
    .result_load_i(load), .z_accel_value_i(z), .temp_value_i(t),
    .aux_converter_value_i(a), .measure_start_i(meas), .int_drive_en_i(int_en),
    .sample_valid_i(s_valid), .sample_data_i(s_data), .sample_ready_o(s_ready),
    .soft_reset_o(soft_rst), .standby_o(standby), .int_hiz_o(hiz),
    .reset_busy_o(busy));

  sample_source sample_source_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hold_i(hold),
    .sample_ready_i(s_ready), .sample_valid_o(s_valid), .sample_data_o(s_data));

  // Free-running core clock at 25 MHz.
  initial core_clk_i = 1'b0;
  always #20 core_clk_i = ~core_clk_i;

  function automatic logic [7:0] hi(input logic [13:0] v);
    return v[13:6];
  endfunction : hi

  function automatic logic [7:0] lo(input logic [13:0] v);
    return {v[5:0], 2'h0};
  endfunction : lo

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask : tick

  // Strobes are raised 1 ns after an edge and held across the taking edge.
  task automatic txn(input logic [7:0] addr);
    txn_start = 1'b1;
    txn_addr  = addr;
    tick(1);
    txn_start = 1'b0;
  endtask : txn

  // Leaves the read strobe up so that back-to-back bytes need no gap.
  task automatic rd(input logic [7:0] exp, input string what);
    byte_rd = 1'b1;
    tick(1);
    chk("read strobe", 16'h0001, rvalid);
    chk(what, exp, rdata);
  endtask : rd

  task automatic wr(input logic [7:0] d);
    byte_wr = 1'b1;
    wdata   = d;
    tick(1);
    byte_wr = 1'b0;
  endtask : wr

  task automatic idle();
    byte_rd = 1'b0;
    tick(1);
    chk("strobe drops", 16'h0000, rvalid);
  endtask : idle

  task automatic pulse_meas_int();
    meas   = 1'b1;
    int_en = 1'b1;
    tick(1);
    meas   = 1'b0;
    int_en = 1'b0;
  endtask : pulse_meas_int

  task automatic t_after_reset();
    chk("standby", 16'h0001, standby);
    chk("hiz", 16'h0001, hiz);
    chk("soft reset", 16'h0000, soft_rst);
    chk("busy", 16'h0000, busy);
    chk("ready", 16'h0001, s_ready);
    txn(ADDR_Z_ACCEL_LOW);
    repeat (6) rd(READ_ZERO, "reset value");
    idle();
    txn(ADDR_RESET_COMMAND);
    rd(READ_ZERO, "reset byte read");
    idle();
    txn(8'h30);
    rd(READ_ZERO, "unmapped read");
    idle();
    $display("test after_reset done");
  endtask : t_after_reset

  task automatic t_results();
    pulse_meas_int();
    z = 14'h2abd;
    t = 14'h1357;
    a = 14'h3c21;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    sample_source_inst.push(16'hbeef);
    tick(2);
    txn(ADDR_Z_ACCEL_LOW);
    rd(lo(z), "z low");
    rd(hi(t), "temp high");
    rd(lo(t), "temp low");
    rd(hi(a), "aux high");
    rd(lo(a), "aux low");
    rd(READ_ZERO, "port skipped");
    idle();
    txn(ADDR_SAMPLE_PORT);
    rd(8'hbe, "word high after skip");
    rd(8'hef, "word low");
    idle();
    $display("test results done");
  endtask : t_results

  task automatic t_queue();
    logic [15:0] w [3];
    w = '{16'h1234, 16'hc3a5, 16'h0ff0};
    hold = 1'b1;
    foreach (w[i]) sample_source_inst.push(w[i]);
    tick(1);
    hold = 1'b0;
    tick(4);
    chk("ready while full", 16'h0000, s_ready);
    chk("source stalled", 16'h0001, s_valid);
    txn(ADDR_SAMPLE_PORT);
    foreach (w[i]) begin
      rd(w[i][15:8], "burst high");
      rd(w[i][7:0], "burst low");
    end
    rd(READ_ZERO, "empty high");
    rd(READ_ZERO, "empty low");
    idle();
    chk("ready when empty", 16'h0001, s_ready);
    $display("test queue done");
  endtask : t_queue

  task automatic t_soft_reset();
    int cnt;
    pulse_meas_int();
    txn(ADDR_TEMP_HIGH);
    wr(RESET_KEY);
    tick(1);
    txn(ADDR_RESET_COMMAND);
    wr(8'h51);
    tick(1);
    chk("standby kept", 16'h0000, standby);
    chk("hiz kept", 16'h0000, hiz);
    chk("no reset pulse", 16'h0000, soft_rst);
    txn(ADDR_Z_ACCEL_LOW);
    rd(lo(z), "z kept");
    idle();
    txn(ADDR_RESET_COMMAND);
    wr(RESET_KEY);
    chk("reset pulse", 16'h0001, soft_rst);
    chk("standby set", 16'h0001, standby);
    chk("hiz set", 16'h0001, hiz);
    cnt = 0;
    while (busy === 1'b1 && cnt < 100) begin
      cnt++;
      tick(1);
      if (cnt == 1) chk("pulse width", 16'h0000, soft_rst);
    end
    chk("busy cycles", 16'(LAT), 16'(cnt));
    // A capture while in standby must leave the cleared result alone.
    z    = 14'h0155;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    txn(ADDR_Z_ACCEL_LOW);
    rd(READ_ZERO, "z cleared");
    idle();
    $display("test soft_reset done");
  endtask : t_soft_reset

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Main sequence: reset for 20 cycles, then the scenarios in turn.
  initial begin
    n_fail = 0;
    n_checks = 0;
    {rst_n_i, txn_start, byte_rd, byte_wr, load, meas, int_en, hold} = 8'h00;
    {txn_addr, wdata} = 16'h0000;
    {z, t, a} = 42'h0;
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_after_reset();
    t_results();
    t_queue();
    t_soft_reset();
    end_of_test();
  end

  // Watchdog: the scenarios need under a hundred cycles, so 5000 means a hang.
  initial begin
    #(40 * 5000);
    n_fail++;
    end_of_test();
  end
endmodule : tb_top
